// ---- design/fsr_pkg.sv ----
// constants for the fault status register bank
// ********************************************************************
// What this block does
// - status words 16 bits, upper byte zero
// - status words read-only, set by detection
// - word one: contactor, pot, memory faults
// - word two: sequencing, voltage, temperature faults
// - word three: overtemp and driver faults
// - word four: precharge, overcurrent, motor faults
// - word five: supply, runtime, encoder, stall
// - word six: bits 2,4,6,7 only
// - word seven: bits 1 to 7
// - word eight: bits 0 to 3
// - each system fault flashed as code
// - sixteen custom flags in two words
// - custom word one codes 51 to 58
// - custom word two codes 59, 61-67
// - set custom flag flashes its code
// - no action mask means flash only
// - action mask per custom flag applied
// ********************************************************************
package fsr_pkg;
   localparam int ADDR_W = 5;
   // register index map
   localparam logic [4:0] OFF_SYS1 = 5'h00;
   localparam logic [4:0] OFF_SYS8 = 5'h07;
   localparam logic [4:0] OFF_CUST1 = 5'h08;
   localparam logic [4:0] OFF_CUST2 = 5'h09;
   localparam logic [4:0] OFF_ACT0 = 5'h10;
   localparam logic [4:0] OFF_ACT15 = 5'h1f;
   localparam logic [4:0] OFF_ACTIVE = 5'h0a;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   // used bit masks for status words two, six, seven and eight
   localparam logic [7:0] MASK_W2 = 8'hdf;
   localparam logic [7:0] MASK_W6 = 8'hd4;
   localparam logic [7:0] MASK_W7 = 8'hfe;
   localparam logic [7:0] MASK_W8 = 8'h0f;
   localparam int NFLAGS = 80;
   // flash timing
   localparam int CLK_HZ = 40_000_000;
   localparam int PULSE_MS = 250;
   localparam int PAUSE_MS = 1000;
   localparam int PULSE_CYC = CLK_HZ / 1000 * PULSE_MS;
   localparam int PAUSE_CYC = CLK_HZ / 1000 * PAUSE_MS;
   // action bit positions
   localparam int ACT_MOTOR = 0;
   localparam int ACT_THROTTLE = 3;
   localparam int ACT_BRAKE = 10;
   // flash code per flag index: word*8 + bit, zero for unused
   function automatic logic [6:0] fsr_code(input logic [6:0] idx);
      logic [6:0] c;
      c = 7'd0;
      unique case (idx)
         7'd0: c = 7'd38;  7'd1: c = 7'd39;  7'd2: c = 7'd45;
         7'd3: c = 7'd42;  7'd4: c = 7'd41;  7'd5: c = 7'd44;
         7'd6: c = 7'd43;  7'd7: c = 7'd46;
         7'd8: c = 7'd47;  7'd9: c = 7'd17;  7'd10: c = 7'd18;
         7'd11: c = 7'd23; 7'd12: c = 7'd24; 7'd14: c = 7'd22;
         7'd15: c = 7'd15;
         7'd16: c = 7'd16; 7'd17: c = 7'd31; 7'd18: c = 7'd32;
         7'd19: c = 7'd33; 7'd20: c = 7'd34; 7'd21: c = 7'd35;
         7'd22: c = 7'd31; 7'd23: c = 7'd32;
         7'd24: c = 7'd14; 7'd25: c = 7'd26; 7'd26: c = 7'd27;
         7'd27: c = 7'd12; 7'd28: c = 7'd13; 7'd29: c = 7'd28;
         7'd30: c = 7'd49; 7'd31: c = 7'd37;
         7'd32: c = 7'd69; 7'd33: c = 7'd29; 7'd34: c = 7'd68;
         7'd35: c = 7'd25; 7'd36: c = 7'd71; 7'd37: c = 7'd72;
         7'd38: c = 7'd36; 7'd39: c = 7'd73;
         7'd42: c = 7'd47; 7'd44: c = 7'd89; 7'd46: c = 7'd87;
         7'd47: c = 7'd97;
         7'd49: c = 7'd91; 7'd50: c = 7'd92; 7'd51: c = 7'd93;
         7'd52: c = 7'd94; 7'd53: c = 7'd75; 7'd54: c = 7'd74;
         7'd55: c = 7'd98;
         7'd56: c = 7'd95; 7'd57: c = 7'd96; 7'd58: c = 7'd47;
         7'd59: c = 7'd99;
         7'd64: c = 7'd59;
         default: begin
            if (idx >= 7'd72 && idx < 7'd80) begin
               c = 7'(idx - 7'd72 + 7'd51);
            end else if (idx > 7'd64 && idx < 7'd72) begin
               c = 7'(idx - 7'd65 + 7'd61);
            end
         end
      endcase
      return c;
   endfunction : fsr_code
endpackage : fsr_pkg

// ---- design/fsr_bank.sv ----
// fault status register bank with flash code sequencer
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module fsr_bank
   import fsr_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic [63:0] fault_raw_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out,
   output logic led_out,
   output logic [6:0] code_out,
   output logic [15:0] action_out
);
   // ********************************************************************
   // fault capture
   // ********************************************************************
   // pins are asynchronous: two stages before use
   logic [63:0] sync1_q;
   logic [63:0] sync2_q;
   logic [63:0] sys_q;
   logic [63:0] used_mask;
   assign used_mask = {MASK_W8, MASK_W7, MASK_W6, 8'hff, 8'hff,
                       8'hff, MASK_W2, 8'hff};
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         sync1_q <= '0;
         sync2_q <= '0;
         sys_q <= '0;
      end else begin
         sync1_q <= fault_raw_in;
         sync2_q <= sync1_q;
         sys_q <= sync2_q & used_mask;
      end
   end

   // ********************************************************************
   // custom faults and action masks
   // ********************************************************************
   logic [7:0] cust1_q;
   logic [7:0] cust2_q;
   logic [15:0] act_q [16];
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         cust1_q <= '0;
         cust2_q <= '0;
      end else if (wr_in) begin
         // only software changes these flags
         if (addr_in == OFF_CUST1) cust1_q <= wdata_in[7:0];
         if (addr_in == OFF_CUST2) cust2_q <= wdata_in[7:0];
      end
   end
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < 16; i++) act_q[i] <= RESET_WORD;
      end else if (wr_in && addr_in >= OFF_ACT0) begin
         act_q[addr_in[3:0]] <= wdata_in;
      end
   end
   logic [15:0] cust;
   assign cust = {cust2_q, cust1_q};
   logic [15:0] act_d;
   always_comb begin
      act_d = '0;
      for (int i = 0; i < 16; i++) begin
         if (cust[i]) act_d = act_d | act_q[i];
      end
   end
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) action_out <= '0;
      else action_out <= act_d;
   end

   // ********************************************************************
   // register read
   // ********************************************************************
   logic [79:0] flags;
   // second custom word scans before the first, matching the code table
   assign flags = {cust1_q, cust2_q, sys_q};
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         rdata_out <= '0;
      end else if (rd_in) begin
         if (addr_in <= OFF_SYS8) begin
            rdata_out <= {8'h00, sys_q[addr_in[2:0]*8 +: 8]};
         end else if (addr_in == OFF_CUST1) begin
            rdata_out <= {8'h00, cust1_q};
         end else if (addr_in == OFF_CUST2) begin
            rdata_out <= {8'h00, cust2_q};
         end else if (addr_in == OFF_ACTIVE) begin
            rdata_out <= {9'h000, code_out};
         end else if (addr_in >= OFF_ACT0) begin
            rdata_out <= act_q[addr_in[3:0]];
         end else begin
            rdata_out <= '0;
         end
      end else begin
         rdata_out <= '0;
      end
   end

   // ********************************************************************
   // flash sequencer
   // ********************************************************************
   // tens blink, gap, units blink, pause, then next active flag
   typedef enum logic [2:0] {S_SCAN, S_TENS, S_GAP, S_UNITS, S_PAUSE}
      fsr_state_e;
   fsr_state_e st_q;
   logic [6:0] idx_q;
   logic [3:0] cnt_q;
   logic [31:0] tmr_q;
   logic phase_q;
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         st_q <= S_SCAN;
         idx_q <= '0;
         cnt_q <= '0;
         tmr_q <= '0;
         phase_q <= 1'b0;
         led_out <= 1'b0;
         code_out <= '0;
      end else begin
         unique case (st_q)
            S_SCAN: begin
               // one flag per cycle, fixed order, wraps
               idx_q <= (idx_q == 7'(NFLAGS - 1)) ? 7'd0 : 7'(idx_q + 7'd1);
               led_out <= 1'b0;
               if (flags[idx_q]) begin
                  code_out <= fsr_code(idx_q);
                  cnt_q <= 4'(fsr_code(idx_q) / 7'd10);
                  tmr_q <= '0;
                  phase_q <= 1'b0;
                  st_q <= S_TENS;
               end
            end
            S_TENS, S_UNITS: begin
               led_out <= ~phase_q;
               if (tmr_q == 32'(PULSE_CYC - 1)) begin
                  tmr_q <= '0;
                  phase_q <= ~phase_q;
                  if (phase_q) begin
                     if (cnt_q <= 4'd1) begin
                        st_q <= (st_q == S_TENS) ? S_GAP : S_PAUSE;
                        cnt_q <= 4'(code_out % 7'd10);
                     end else begin
                        cnt_q <= 4'(cnt_q - 4'd1);
                     end
                  end
               end else begin
                  tmr_q <= 32'(tmr_q + 32'd1);
               end
            end
            S_GAP, S_PAUSE: begin
               led_out <= 1'b0;
               if (tmr_q == 32'(PAUSE_CYC - 1)) begin
                  tmr_q <= '0;
                  phase_q <= 1'b0;
                  st_q <= (st_q == S_GAP) ? S_UNITS : S_SCAN;
                  if (st_q == S_PAUSE) code_out <= '0;
               end else begin
                  tmr_q <= 32'(tmr_q + 32'd1);
               end
            end
         endcase
      end
   end

   // ********************************************************************
   // checks
   // ********************************************************************
   property p_upper_zero;
      @(posedge clk_in) disable iff (!reset_n_in)
      rd_in && addr_in <= OFF_SYS8 |=> rdata_out[15:8] == 8'h00;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("status upper byte not zero");
   property p_unused;
      @(posedge clk_in) disable iff (!reset_n_in)
      (sys_q & ~used_mask) == 64'h0;
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused status bit set");
   property p_cust_hold;
      @(posedge clk_in) disable iff (!reset_n_in)
      !(wr_in && addr_in == OFF_CUST1) |=> $stable(cust1_q);
   endproperty
   a_cust_hold: assert property (p_cust_hold)
      else $error("custom word changed without write");
   property p_action;
      @(posedge clk_in) disable iff (!reset_n_in)
      cust == 16'h0 |=> action_out == 16'h0;
   endproperty
   a_action: assert property (p_action)
      else $error("action without custom fault");
   property p_sys_follow;
      @(posedge clk_in) disable iff (!reset_n_in)
      fault_raw_in[0] [*3] |=> sys_q[0];
   endproperty
   a_sys_follow: assert property (p_sys_follow)
      else $error("status bit did not follow fault");
   property p_flash;
      @(posedge clk_in) disable iff (!reset_n_in)
      st_q == S_SCAN && flags[idx_q] |=> code_out != 7'd0 && st_q == S_TENS;
   endproperty
   a_flash: assert property (p_flash)
      else $error("active flag not flashed");
endmodule : fsr_bank
`default_nettype wire

// ---- sim/fsr_led_model.sv ----
// status led observer that counts flash pulses
`timescale 1ns/100ps
`default_nettype none
module fsr_led_model (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic led_in,
   output logic [15:0] pulses_out
);
   logic led_q;
   // counted on rising edges only, so a long on-time is one pulse
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         led_q <= 1'b0;
         pulses_out <= 16'h0000;
      end else begin
         led_q <= led_in;
         if (led_in && !led_q) begin
            pulses_out <= pulses_out + 16'h0001;
         end
      end
   end
endmodule : fsr_led_model
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench for the fault status register bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import fsr_pkg::*;
   logic clk_in, reset_n_in, wr_in, rd_in, led_out;
   logic [63:0] fault_raw_in;
   logic [4:0] addr_in;
   logic [15:0] wdata_in, rdata_out, action_out, pulses, d;
   logic [6:0] code_out;
   int failures = 0;
   int num_checks = 0;
   fsr_bank i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .fault_raw_in(fault_raw_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .led_out(led_out), .code_out(code_out), .action_out(action_out));
   fsr_led_model i_led (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .led_in(led_out), .pulses_out(pulses));
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim();
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim
   task automatic do_reset();
      fault_raw_in <= 64'h0;
      reset_n_in <= 1'b0;
      repeat (5) @(posedge clk_in);
      reset_n_in <= 1'b1;
   endtask : do_reset
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= v;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      d = rdata_out;
   endtask : rd
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_status();
      logic [7:0] exp [8] = '{8'hff, 8'hdf, 8'hff, 8'hff, 8'hff, 8'hd4,
         8'hfe, 8'h0f};
      for (int i = 0; i < 11; i++) begin
         rd(5'(i));
         check(d, 16'h0000);
      end
      fault_raw_in <= '1;
      repeat (4) @(posedge clk_in);
      for (int i = 0; i < 8; i++) begin
         rd(5'(i));
         check(d, {8'h00, exp[i]});
      end
      // a software write must not disturb detected state
      wr(OFF_SYS1, 16'h0000);
      rd(OFF_SYS1);
      check(d, 16'h00ff);
      fault_raw_in <= 64'h0;
      repeat (4) @(posedge clk_in);
      rd(OFF_SYS8);
      check(d, 16'h0000);
   endtask : t_status
   task automatic t_custom();
      do_reset();
      wr(OFF_CUST1, 16'hffff);
      rd(OFF_CUST1);
      check(d, 16'h00ff);
      wr(OFF_CUST2, 16'h0081);
      rd(OFF_CUST2);
      check(d, 16'h0081);
      rd(5'h0b);
      check(d, 16'h0000);
      wr(OFF_CUST1, 16'h0000);
      rd(OFF_CUST1);
      check(d, 16'h0000);
      wr(OFF_CUST2, 16'h0000);
      wr(OFF_ACT0, 16'h0409);
      wr(OFF_CUST1, 16'h0002);
      @(posedge clk_in);
      @(negedge clk_in);
      check(action_out, 16'h0000);
      wr(OFF_CUST1, 16'h0003);
      @(posedge clk_in);
      @(negedge clk_in);
      check(action_out, 16'h0409);
      wr(OFF_CUST1, 16'h0000);
      @(posedge clk_in);
      @(negedge clk_in);
      check(action_out, 16'h0000);
   endtask : t_custom
   task automatic t_flash();
      int f [10] = '{0, 7, 15, 44, 59, 64, 65, 71, 72, 79};
      int c [10] = '{38, 46, 15, 89, 99, 59, 61, 67, 51, 58};
      int n;
      for (int k = 0; k < 10; k++) begin
         do_reset();
         if (f[k] < 64) begin
            fault_raw_in <= 64'h1 << f[k];
         end else begin
            wr(f[k] >= 72 ? OFF_CUST1 : OFF_CUST2, 16'h1 << (f[k] % 8));
         end
         n = 0;
         // long flash timing: only the first pulse is awaited
         while ((code_out === 7'h00 || pulses === 16'h0000) && n < 400) begin
            @(negedge clk_in);
            n++;
         end
         if (n >= 400) begin
            failures++;
            end_sim();
         end
         check({9'h000, code_out}, 16'(c[k]));
         rd(OFF_ACTIVE);
         check(d, 16'(c[k]));
      end
   endtask : t_flash
   initial begin
      reset_n_in = 1'b0;
      wr_in = 1'b0;
      rd_in = 1'b0;
      addr_in = 5'h00;
      wdata_in = 16'h0000;
      fault_raw_in = 64'h0;
      do_reset();
      t_status();
      t_custom();
      t_flash();
      end_sim();
   end
endmodule : testbench
`default_nettype wire
